// ==== logic/option_register.sv ====
// Write-once system option register with its stop, watchdog and opcode controls.
`timescale 1ns/10ps
`default_nettype none
`include "option_reg_params.svh"

module option_register
  import option_reg_pkg::*;
#(
  parameter int WDOG_LONG_EXP = `WDOG_LONG_EXP,
  parameter int WDOG_SHORT_EXP = `WDOG_SHORT_EXP,
  parameter int WDOG_SUB_EXP = `WDOG_SUB_EXP,
  parameter int REC_SHORT = `REC_SHORT_CYCLES,
  parameter int REC_LONG = `REC_LONG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr_en,
  input wire logic cpu_rd_en,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_valid,
  output logic write_used,
  output logic short_stop_recovery,
  output logic watchdog_period_select,
  output logic stop_enable,
  output logic watchdog_disable,
  output logic watchdog_enable,
  output logic [WDOG_LONG_EXP:0] watchdog_period_cycles,
  input wire logic stop_opcode,
  output logic stop_entry,
  output logic illegal_opcode,
  input wire logic stop_wake,
  input wire logic wake_by_reset_pin,
  output logic stop_recovery_busy,
  output logic stop_recovery_done
);

  localparam int PW = WDOG_LONG_EXP + 1;
  localparam logic [7:0] RESET_BYTE = `OPT_RESET_VALUE;

  // The period arithmetic only works with ordered exponents.
  initial begin
    if (WDOG_SUB_EXP >= WDOG_SHORT_EXP || WDOG_SHORT_EXP >= WDOG_LONG_EXP) begin
      $error("option_register: watchdog exponents out of order");
    end
  end

  localparam logic [PW-1:0] ONE_W = PW'(1);
  localparam logic [PW-1:0] WDOG_SHORT_PERIOD =
    (ONE_W << WDOG_SHORT_EXP) - (ONE_W << WDOG_SUB_EXP);
  localparam logic [PW-1:0] WDOG_LONG_PERIOD =
    (ONE_W << WDOG_LONG_EXP) - (ONE_W << WDOG_SUB_EXP);

  option_fields_t option_reg;
  logic written_reg;
  logic hit;
  logic [7:0] option_byte;

  assign hit = (cpu_addr == `OPT_REG_ADDR);
  // Upper nibble is unimplemented and always reads zero.
  assign option_byte = {4'h0, option_reg};

  // Write-once latch; the write flag is what re-arms on reset.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      option_reg <= option_fields_t'(RESET_BYTE[`OPT_FIELD_MSB:0]);
      written_reg <= 1'b0;
    end else if (cpu_wr_en && hit && !written_reg) begin
      option_reg <= option_fields_t'(cpu_wdata[`OPT_FIELD_MSB:0]);
      written_reg <= 1'b1;
    end
  end

  // Read data returns one cycle after the strobe; other addresses read zero.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_rdata <= 8'h00;
      cpu_rdata_valid <= 1'b0;
    end else begin
      cpu_rdata <= (cpu_rd_en && hit) ? option_byte : 8'h00;
      cpu_rdata_valid <= cpu_rd_en;
    end
  end

  // Option outputs are copies so that consumers see flops, one cycle late.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      write_used <= 1'b0;
      short_stop_recovery <= 1'b0;
      watchdog_period_select <= 1'b0;
      stop_enable <= 1'b0;
      watchdog_disable <= 1'b0;
      watchdog_enable <= 1'b1;
    end else begin
      write_used <= written_reg;
      short_stop_recovery <= option_reg.short_stop_recovery;
      watchdog_period_select <= option_reg.watchdog_period_select;
      stop_enable <= option_reg.stop_enable;
      watchdog_disable <= option_reg.watchdog_disable;
      watchdog_enable <= !option_reg.watchdog_disable;
    end
  end

  // Watchdog timeout selection; the counter itself lives elsewhere.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      watchdog_period_cycles <= WDOG_LONG_PERIOD;
    end else begin
      watchdog_period_cycles <= option_reg.watchdog_period_select ?
        WDOG_SHORT_PERIOD : WDOG_LONG_PERIOD;
    end
  end

  // A decoded stop opcode either enters stop or traps as illegal, never both.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stop_entry <= 1'b0;
      illegal_opcode <= 1'b0;
    end else begin
      stop_entry <= stop_opcode && option_reg.stop_enable;
      illegal_opcode <= stop_opcode && !option_reg.stop_enable;
    end
  end

  // A wake through the reset pin ignores the short bit, since the pin
  // may be used while an external crystal is still starting up.
  stop_recovery_if rec_link ();
  assign rec_link.start = stop_wake;
  assign rec_link.long_sel = !option_reg.short_stop_recovery || wake_by_reset_pin;

  stop_recovery_timer #(
    .SHORT_CYCLES(REC_SHORT),
    .LONG_CYCLES(REC_LONG)
  ) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rec(rec_link.timer)
  );

  assign stop_recovery_busy = rec_link.busy;
  assign stop_recovery_done = rec_link.done;

  // Once used, the write opportunity stays spent and the fields hold.
  chk_write_once_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    written_reg |=> (written_reg && $stable(option_reg)))
    else $error("option register changed after its single write");

  chk_first_write_takes: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_wr_en && hit && !written_reg) |=>
      (option_reg == $past(cpu_wdata[3:0]) && written_reg))
    else $error("first write to option register not latched");

  chk_reset_clears: assert property (@(posedge clk_sys)
    !resetn |-> (option_reg == 4'h0 && !written_reg))
    else $error("option register not cleared by reset");

  chk_read_returns: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cpu_rd_en && cpu_addr == 16'h001f) |=> (cpu_rdata == $past(option_byte)))
    else $error("read of option register returned wrong data");

  chk_upper_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    cpu_rdata[7:4] == 4'h0)
    else $error("upper option bits read nonzero");

  chk_long_on_pin: assert property (@(posedge clk_sys) disable iff (!resetn)
    (stop_wake && wake_by_reset_pin && !rec_link.busy) |->
      ##33 (rec_link.busy && !rec_link.done))
    else $error("reset-pin wake used a short recovery");

  chk_wdog_period: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 (watchdog_period_cycles ==
      ($past(option_reg.watchdog_period_select) ? 19'h01ff0 : 19'h3fff0)))
    else $error("watchdog period does not match select bit");

  chk_stop_legal: assert property (@(posedge clk_sys) disable iff (!resetn)
    stop_opcode |=> (stop_entry == $past(option_reg.stop_enable)
      && illegal_opcode == !$past(option_reg.stop_enable)))
    else $error("stop opcode handling disagrees with stop enable");

  chk_wdog_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 (watchdog_enable == !$past(option_reg.watchdog_disable)))
    else $error("watchdog enable disagrees with disable bit");

  cov_second_write: cover property (@(posedge clk_sys) disable iff (!resetn)
    written_reg && cpu_wr_en && hit);
  cov_illegal_stop: cover property (@(posedge clk_sys) disable iff (!resetn)
    illegal_opcode);
  cov_recovery_end: cover property (@(posedge clk_sys) disable iff (!resetn)
    rec_link.done);

endmodule

`default_nettype wire

// ==== logic/stop_recovery_timer.sv ====
// Counts the stop-mode recovery delay and pulses done when it expires.
`timescale 1ns/10ps
`default_nettype none
`include "option_reg_params.svh"

module stop_recovery_timer
  import option_reg_pkg::*;
#(
  parameter int SHORT_CYCLES = `REC_SHORT_CYCLES,
  parameter int LONG_CYCLES = `REC_LONG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  stop_recovery_if.timer rec
);

  localparam int CNT_W = $clog2(LONG_CYCLES);

  // The counter must hold both delays minus one.
  initial begin
    if (SHORT_CYCLES < 1 || LONG_CYCLES < 2 || LONG_CYCLES < SHORT_CYCLES) begin
      $error("stop_recovery_timer: delay parameters out of range");
    end
  end

  localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(SHORT_CYCLES - 1);
  localparam logic [CNT_W-1:0] LONG_LOAD = CNT_W'(LONG_CYCLES - 1);

  rec_state_t state_reg;
  logic [CNT_W-1:0] count_reg;
  logic busy_reg;
  logic done_reg;

  // Sequencer; a start while busy is ignored so one wake gives one done.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= REC_IDLE;
    end else begin
      case (state_reg)
        REC_IDLE: begin
          if (rec.start) begin
            state_reg <= REC_COUNT;
          end
        end
        REC_COUNT: begin
          if (count_reg == '0) begin
            state_reg <= REC_DONE;
          end
        end
        REC_DONE: begin
          state_reg <= REC_IDLE;
        end
        default: begin
          state_reg <= REC_IDLE;
        end
      endcase
    end
  end

  // Delay counter; the load picks the short or long figure.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (state_reg == REC_IDLE && rec.start) begin
      count_reg <= rec.long_sel ? LONG_LOAD : SHORT_LOAD;
    end else if (state_reg == REC_COUNT && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // Status flags are flops of their own, so the top's outputs need no gates after them.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg == REC_IDLE) ? rec.start : (state_reg == REC_COUNT);
      done_reg <= (state_reg == REC_COUNT) && (count_reg == '0);
    end
  end

  assign rec.busy = busy_reg;
  assign rec.done = done_reg;

  // Done rises SHORT_CYCLES edges after the start, so it is first sampled one edge later.
  chk_short_delay_len: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_reg == REC_IDLE && rec.start && !rec.long_sel) |-> ##33 rec.done)
    else $error("short recovery did not finish after 32 cycles");

endmodule

`default_nettype wire

// ==== shared/option_reg_params.svh ====
// Constants for the write-once system option register and its consumers.
`ifndef OPTION_REG_PARAMS_SVH
`define OPTION_REG_PARAMS_SVH

// Register location in the I/O space of the CPU bus.
`define OPT_REG_ADDR 16'h001f

// Field positions inside the option byte.
`define OPT_BIT_SHORT_REC 3
`define OPT_BIT_WDOG_PERIOD 2
`define OPT_BIT_STOP_EN 1
`define OPT_BIT_WDOG_DIS 0
`define OPT_FIELD_MSB 3

// Value of the option byte after any reset.
`define OPT_RESET_VALUE 8'h00

// Stop-mode recovery delays in oscillator clock cycles.
`define REC_SHORT_CYCLES 32
`define REC_LONG_CYCLES 4096

// Watchdog timeout exponents: period is 2^hi minus 2^lo oscillator cycles.
`define WDOG_SHORT_EXP 13
`define WDOG_LONG_EXP 18
`define WDOG_SUB_EXP 4

`endif

// ==== shared/option_reg_pkg.sv ====
// Types shared by the option register and its stop recovery timer.
package option_reg_pkg;

  // One-hot states of the stop recovery timer.
  typedef enum logic [2:0] {
    REC_IDLE  = 3'b001,
    REC_COUNT = 3'b010,
    REC_DONE  = 3'b100
  } rec_state_t;

  // Latched option fields in register bit order.
  typedef struct packed {
    logic short_stop_recovery;
    logic watchdog_period_select;
    logic stop_enable;
    logic watchdog_disable;
  } option_fields_t;

endpackage

// ==== shared/stop_recovery_if.sv ====
// Link between the option register and the stop recovery timer.
`timescale 1ns/10ps
`default_nettype none

interface stop_recovery_if;
  logic start;
  logic long_sel;
  logic busy;
  logic done;

  // The option block requests a delay; the timer reports its progress.
  modport ctrl (output start, output long_sel, input busy, input done);
  modport timer (input start, input long_sel, output busy, output done);
endinterface

`default_nettype wire

// ==== verif/tb_write_once_option_register.sv ====
// Self-checking bench for the write-once system option register.
`timescale 1ns/10ps
`default_nettype none

module tb_write_once_option_register;
  logic clk_sys, resetn, cpu_wr_en, cpu_rd_en, stop_opcode, stop_wake, wake_by_reset_pin;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata;
  logic cpu_rdata_valid, write_used, watchdog_enable, stop_entry, illegal_opcode;
  logic short_stop_recovery, watchdog_period_select, stop_enable, watchdog_disable;
  logic stop_recovery_busy, stop_recovery_done;
  logic [18:0] watchdog_period_cycles;
  int num_errors = 0;
  int cmp_count = 0;

  // The long delay is shortened so the run stays brief; expectations use the same value.
  option_register #(.REC_LONG(64)) u_option_register (
    .clk_sys(clk_sys), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wr_en(cpu_wr_en),
    .cpu_rd_en(cpu_rd_en), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rdata_valid(cpu_rdata_valid), .write_used(write_used),
    .short_stop_recovery(short_stop_recovery), .watchdog_period_select(watchdog_period_select),
    .stop_enable(stop_enable), .watchdog_disable(watchdog_disable),
    .watchdog_enable(watchdog_enable), .watchdog_period_cycles(watchdog_period_cycles),
    .stop_opcode(stop_opcode), .stop_entry(stop_entry), .illegal_opcode(illegal_opcode),
    .stop_wake(stop_wake), .wake_by_reset_pin(wake_by_reset_pin),
    .stop_recovery_busy(stop_recovery_busy), .stop_recovery_done(stop_recovery_done));

  // A 5 ns system clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Reset is asserted off the clock edge and released at a falling edge.
  task automatic do_reset();
    resetn = 1'b0;
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
  endtask

  // Bus tasks start and end on a falling edge, so strobes never change at a sampling edge.
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    cpu_addr = addr;
    cpu_wdata = data;
    cpu_wr_en = 1'b1;
    @(negedge clk_sys);
    cpu_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    cpu_addr = addr;
    cpu_rd_en = 1'b1;
    @(negedge clk_sys);
    cpu_rd_en = 1'b0;
    check("read valid", 32'(cpu_rdata_valid), 32'h1);
    check("read data", 32'(cpu_rdata), 32'(exp));
  endtask

  // Field outputs lag the register by a cycle, so call this after a read.
  task automatic fields(input logic [3:0] f);
    check("option bits", 32'({short_stop_recovery, watchdog_period_select, stop_enable,
      watchdog_disable}), 32'(f));
    check("watchdog enable", 32'(watchdog_enable), 32'(!f[0]));
    check("watchdog period", 32'(watchdog_period_cycles), (32'h1 << (f[2] ? 13 : 18)) - 32'h10);
  endtask

  task automatic stop_op(input logic legal);
    stop_opcode = 1'b1;
    @(negedge clk_sys);
    stop_opcode = 1'b0;
    check("stop entry", 32'(stop_entry), 32'(legal));
    check("illegal opcode", 32'(illegal_opcode), 32'(!legal));
  endtask

  // One idle cycle first: a wake seen while the last delay is still busy would be dropped.
  task automatic wake(input logic pin, input int n);
    int k;
    k = 0;
    @(negedge clk_sys);
    check("busy idle", 32'(stop_recovery_busy), 32'h0);
    wake_by_reset_pin = pin;
    stop_wake = 1'b1;
    @(negedge clk_sys);
    stop_wake = 1'b0;
    while (stop_recovery_done !== 1'b1) begin
      @(negedge clk_sys);
      k++;
      if (k > 5000) begin
        num_errors++;
        end_sim();
      end
    end
    check("recovery cycles", 32'(k), 32'(n));
    check("busy at done", 32'(stop_recovery_busy), 32'h1);
    wake_by_reset_pin = 1'b0;
  endtask

  // Main sequence.
  initial begin
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    cpu_wr_en = 1'b0;
    cpu_rd_en = 1'b0;
    stop_opcode = 1'b0;
    stop_wake = 1'b0;
    wake_by_reset_pin = 1'b0;
    do_reset();
    rd(16'h001f, 8'h00);
    fields(4'h0);
    check("write used", 32'(write_used), 32'h0);
    stop_op(1'b0);
    wake(1'b0, 64);
    $display("Test reset defaults finished.");
    wr(16'h001e, 8'hff);
    rd(16'h001e, 8'h00);
    wr(16'h001f, 8'hfd);
    rd(16'h001f, 8'h0d);
    fields(4'hd);
    wr(16'h001f, 8'h02);
    rd(16'h001f, 8'h0d);
    check("write used", 32'(write_used), 32'h1);
    stop_op(1'b0);
    wake(1'b0, 32);
    wake(1'b1, 64);
    $display("Test first write finished.");
    do_reset();
    rd(16'h001f, 8'h00);
    wr(16'h001f, 8'h02);
    rd(16'h001f, 8'h02);
    fields(4'h2);
    stop_op(1'b1);
    $display("Test reset rearm finished.");
    end_sim();
  end
endmodule

`default_nettype wire
